// file: logic/msr_defs.svh
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

`define MSR_ADDR_W 6
`define MSR_OFS_CTRL 6'h12
`define MSR_OFS_STRENGTH 6'h13
`define MSR_OFS_SYNC 6'h14

`define MSR_CTRL_USED 11
`define MSR_CORR_HI 10
`define MSR_CORR_LO 6
`define MSR_AVG_BIT 5
`define MSR_PHASE_BIT 4
`define MSR_TXM_HI 3
`define MSR_TXM_LO 2
`define MSR_RXM_HI 1
`define MSR_RXM_LO 0
`define MSR_THR_HI 15
`define MSR_THR_LO 8

`define MSR_CTRL_RST 11'h500
`define MSR_THR_RST 8'he0
`define MSR_STRENGTH_INVALID 8'h80
`define MSR_SYNC_RST 16'ha70f
`define MSR_LFSR_RST 16'hffff
`define MSR_LFSR_POLY 16'h1021

`define MSR_NIB_W 4
`define MSR_NIB_ALL1 4'hf
`define MSR_NIB_ZERO 4'h0
`define MSR_SYNC_LAST 2'h3
`define MSR_WIN_LAST 3'h4
`define MSR_WIN_FULL 3'h5

`define MSR_TX_BUF 2'h0
`define MSR_TX_SER 2'h1
`define MSR_TX_LOOP 2'h2
`define MSR_TX_RAND 2'h3
`define MSR_RX_BUF 2'h0
`define MSR_RX_SER 2'h1
`define MSR_RX_LOOP 2'h2
`define MSR_RX_RSVD 2'h3

`define MSR_CCA_RSVD 2'h0
`define MSR_CCA_LEVEL 2'h1
`define MSR_CCA_FRAME 2'h2
`define MSR_CCA_BOTH 2'h3

`define MSR_AVG_DEPTH 8
`define MSR_AVG_PTR_W 3
`define MSR_AVG_FULL 4'h8
`define MSR_AVG_NEAR 4'h7
`define MSR_AVG_SHIFT 3
`define MSR_SUM_W 11

`endif

// file: logic/msr_pkg.sv
package msr_pkg;
    typedef logic [7:0] msr_db_t;
    typedef logic [3:0] msr_nib_t;
    typedef enum {SQ_IDLE, SQ_SYNC, SQ_DATA} msr_txseq_t;
endpackage

// file: logic/msr_avg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface msr_avg_if;
    logic tick;
    logic clear;
    msr_pkg::msr_db_t sample;
    msr_pkg::msr_db_t avg;
    logic valid;
    modport src(output tick, output clear, output sample, input avg, input valid);
    modport avgr(input tick, input clear, input sample, output avg, output valid);
endinterface
`default_nettype wire

// file: logic/msr_strength_avg.sv
`timescale 1ns/1ps
`default_nettype none
`include "msr_defs.svh"
module msr_strength_avg (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    msr_avg_if.avgr bus
);
    import msr_pkg::*;
    localparam int PW = `MSR_AVG_PTR_W;
    msr_db_t mem_ff [`MSR_AVG_DEPTH];
    logic [PW-1:0] ptr_ff;
    logic [3:0] cnt_ff;
    logic [`MSR_SUM_W-1:0] sum_ff;
    logic [`MSR_SUM_W-1:0] nxt_sum;
    msr_db_t rd_ff;
    msr_db_t avg_ff;
    logic valid_ff;

    assign nxt_sum = sum_ff + {{3{bus.sample[7]}}, bus.sample} - {{3{rd_ff[7]}}, rd_ff};
    assign bus.avg = avg_ff;
    assign bus.valid = valid_ff;

    // One history entry per sample of the window.
    for (genvar gi = 0; gi < `MSR_AVG_DEPTH; gi++) begin : g_ent
        always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
                mem_ff[gi] <= 8'h00;
            end else if (ce_in) begin
                if (bus.clear) begin
                    mem_ff[gi] <= 8'h00;
                end else if (bus.tick && ptr_ff == PW'(gi)) begin
                    mem_ff[gi] <= bus.sample;
                end
            end
        end
    end

    // Oldest entry is read out through a register.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_ff <= 8'h00;
        end else if (ce_in) begin
            rd_ff <= mem_ff[ptr_ff];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ptr_ff <= '0;
            cnt_ff <= 4'h0;
            sum_ff <= '0;
            valid_ff <= 1'b0;
            avg_ff <= `MSR_STRENGTH_INVALID;
        end else if (ce_in) begin
            if (bus.clear) begin
                ptr_ff <= '0;
                cnt_ff <= 4'h0;
                sum_ff <= '0;
                valid_ff <= 1'b0;
                avg_ff <= `MSR_STRENGTH_INVALID;
            end else if (bus.tick) begin
                ptr_ff <= ptr_ff + PW'(1);
                sum_ff <= nxt_sum;
                if (cnt_ff != `MSR_AVG_FULL) begin
                    cnt_ff <= cnt_ff + 4'h1;
                end
                if (cnt_ff >= `MSR_AVG_NEAR) begin
                    valid_ff <= 1'b1;
                    avg_ff <= nxt_sum[`MSR_SUM_W-1:`MSR_AVG_SHIFT];
                end
            end
        end
    end
endmodule // msr_strength_avg
`default_nettype wire

// file: logic/msr_modem_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "msr_defs.svh"
// Behaviour
// - Delimiter search only after correlator reaches threshold.
// - Offset filter frozen after preamble unless averaging.
// - Phase select: reversed phase for both directions.
// - Transmit mode 0 reads the transmit buffer.
// - Transmit mode 1 sends serial data endlessly.
// - Transmit mode 2 loops buffer, ignores underflow.
// - Transmit mode 3 sends pseudo-random checksum data.
// - Receive mode 0 stores into receive buffer.
// - Receive mode 1 drives data on pins.
// - Receive mode 2 loops buffer, ignores overflow.
// - Channel threshold is signed, resets to -32.
// - Clear-channel flag while strength below threshold.
// - Strength byte is read-only signed dB estimate.
// - Strength averaged over eight symbols, then ready.
// - Strength resets to -128, meaning not valid.
// - Sync word handled low nibble first.
// - Transmit replaces all-ones sync nibbles with zero.
// - Receive treats all-ones sync nibbles as wildcards.
// - Receive needs a zero before first non-wildcard nibble.
// - Level rule uses hysteresis below threshold.
module msr_modem_regs (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [`MSR_ADDR_W-1:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [4:0] corr_level_in,
    input wire logic preamble_match_in,
    input wire logic rx_en_in,
    input wire msr_pkg::msr_db_t strength_sample_in,
    input wire logic sym_tick_in,
    input wire logic [1:0] clear_channel_rule_select_in,
    input wire logic [2:0] clear_channel_hysteresis_in,
    input wire logic rx_frame_active_in,
    input wire logic rx_sym_valid_in,
    input wire msr_pkg::msr_nib_t rx_sym_in,
    input wire logic rx_frame_end_in,
    input wire logic tx_start_in,
    input wire logic tx_stop_in,
    input wire msr_pkg::msr_nib_t tx_buf_nib_in,
    input wire msr_pkg::msr_nib_t tx_ser_nib_in,
    output logic [15:0] reg_rdata_out,
    output logic delim_search_en_out,
    output logic delim_found_out,
    output logic offset_hold_out,
    output logic phase_reverse_out,
    output logic signal_strength_ready_out,
    output logic clear_channel_flag_out,
    output logic rx_buf_wr_out,
    output msr_pkg::msr_nib_t rx_pin_data_out,
    output logic rx_wrap_out,
    output logic rx_endless_out,
    output msr_pkg::msr_nib_t tx_nib_out,
    output logic tx_nib_valid_out,
    output logic tx_buf_rd_out,
    output logic tx_wrap_out,
    output logic tx_endless_out,
    output logic tx_busy_out
);
    import msr_pkg::*;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    logic [`MSR_CTRL_USED-1:0] ctrl_ff;
    msr_db_t thr_ff;
    logic [15:0] sync_ff;
    logic [15:0] nxt_rdata;
    logic wr_ctrl;
    logic wr_strength;
    logic wr_sync;
    logic [4:0] correlator_threshold;
    logic [1:0] tx_mode;
    logic [1:0] rx_mode;
    msr_avg_if avg_bus();

    assign wr_ctrl = ce_in && reg_wr_in && reg_addr_in == `MSR_OFS_CTRL;
    assign wr_strength = ce_in && reg_wr_in && reg_addr_in == `MSR_OFS_STRENGTH;
    assign wr_sync = ce_in && reg_wr_in && reg_addr_in == `MSR_OFS_SYNC;
    assign correlator_threshold = ctrl_ff[`MSR_CORR_HI:`MSR_CORR_LO];
    assign tx_mode = ctrl_ff[`MSR_TXM_HI:`MSR_TXM_LO];
    assign rx_mode = ctrl_ff[`MSR_RXM_HI:`MSR_RXM_LO];

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ctrl_ff <= `MSR_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_ff <= reg_wdata_in[`MSR_CTRL_USED-1:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            thr_ff <= `MSR_THR_RST;
        end else if (wr_strength) begin
            thr_ff <= reg_wdata_in[`MSR_THR_HI:`MSR_THR_LO];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync_ff <= `MSR_SYNC_RST;
        end else if (wr_sync) begin
            sync_ff <= reg_wdata_in;
        end
    end

    always_comb begin
        case (reg_addr_in)
            `MSR_OFS_CTRL: nxt_rdata = {{(16 - `MSR_CTRL_USED){1'b0}}, ctrl_ff};
            `MSR_OFS_STRENGTH: nxt_rdata = {thr_ff, avg_bus.avg};
            `MSR_OFS_SYNC: nxt_rdata = sync_ff;
            default: nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (ce_in && reg_rd_in) begin
            reg_rdata_out <= nxt_rdata;
        end
    end

    // Strength averaging runs only while the receiver is enabled.
    assign avg_bus.tick = sym_tick_in && rx_en_in;
    assign avg_bus.clear = !rx_en_in;
    assign avg_bus.sample = strength_sample_in;

    msr_strength_avg u_avg (
        .clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .bus(avg_bus.avgr)
    );

    logic signed [8:0] s_val;
    logic signed [8:0] s_thr;
    logic signed [8:0] s_thr_lo;
    logic level_ff;
    logic nxt_level;
    logic nxt_flag;

    assign s_val = {avg_bus.avg[7], avg_bus.avg};
    assign s_thr = {thr_ff[7], thr_ff};
    assign s_thr_lo = s_thr - $signed({6'h00, clear_channel_hysteresis_in});

    always_comb begin
        nxt_level = level_ff;
        if (s_val < s_thr_lo) begin
            nxt_level = 1'b1;
        end else if (s_val >= s_thr) begin
            nxt_level = 1'b0;
        end
    end

    always_comb begin
        case (clear_channel_rule_select_in)
            `MSR_CCA_FRAME: nxt_flag = !rx_frame_active_in;
            `MSR_CCA_BOTH: nxt_flag = nxt_level && !rx_frame_active_in;
            default: nxt_flag = nxt_level;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level_ff <= 1'b0;
            clear_channel_flag_out <= 1'b0;
            signal_strength_ready_out <= 1'b0;
        end else if (ce_in) begin
            level_ff <= nxt_level;
            clear_channel_flag_out <= nxt_flag;
            signal_strength_ready_out <= avg_bus.valid;
        end
    end

    logic preamble_lock_ff;
    logic nxt_preamble_lock;

    assign nxt_preamble_lock = rx_en_in && (preamble_lock_ff || preamble_match_in);

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            preamble_lock_ff <= 1'b0;
            offset_hold_out <= 1'b0;
        end else if (ce_in) begin
            preamble_lock_ff <= nxt_preamble_lock;
            offset_hold_out <= !ctrl_ff[`MSR_AVG_BIT] && nxt_preamble_lock;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase_reverse_out <= 1'b0;
        end else if (ce_in) begin
            phase_reverse_out <= ctrl_ff[`MSR_PHASE_BIT];
        end
    end

    // Receive window, index 0 is the newest symbol.
    logic [4:0][3:0] win_ff;
    logic [4:0][3:0] nxt_win;
    logic [2:0] fill_ff;
    logic [3:0] nib_ok;
    logic [2:0] first_req;
    logic zero_ok;
    logic match;
    logic frame_lock_ff;

    assign nxt_win = {win_ff[3:0], rx_sym_in};

    for (genvar gi = 0; gi < 4; gi++) begin : g_nib
        assign nib_ok[gi] = sync_ff[gi*4 +: 4] == `MSR_NIB_ALL1 ||
            nxt_win[3 - gi] == sync_ff[gi*4 +: 4];
    end

    always_comb begin
        first_req = `MSR_WIN_LAST;
        for (int i = 3; i >= 0; i--) begin
            if (sync_ff[i*4 +: 4] != `MSR_NIB_ALL1) begin
                first_req = 3'(i);
            end
        end
    end

    assign zero_ok = nxt_win[`MSR_WIN_LAST - first_req] == `MSR_NIB_ZERO;
    assign match = (&nib_ok) && zero_ok && fill_ff >= `MSR_WIN_LAST;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            win_ff <= '0;
            fill_ff <= 3'h0;
        end else if (ce_in) begin
            if (!rx_en_in) begin
                win_ff <= '0;
                fill_ff <= 3'h0;
            end else if (rx_sym_valid_in) begin
                win_ff <= nxt_win;
                if (fill_ff != `MSR_WIN_FULL) begin
                    fill_ff <= fill_ff + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            delim_search_en_out <= 1'b0;
        end else if (ce_in) begin
            delim_search_en_out <= corr_level_in >= correlator_threshold;
        end
    end

    logic found;
    assign found = rx_en_in && rx_sym_valid_in && delim_search_en_out && !frame_lock_ff && match;

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            frame_lock_ff <= 1'b0;
            delim_found_out <= 1'b0;
        end else if (ce_in) begin
            delim_found_out <= found;
            if (!rx_en_in) begin
                frame_lock_ff <= 1'b0;
            end else if (found) begin
                frame_lock_ff <= 1'b1;
            end else if (rx_frame_end_in && !rx_endless_out) begin
                frame_lock_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rx_buf_wr_out <= 1'b0;
            rx_pin_data_out <= `MSR_NIB_ZERO;
            rx_wrap_out <= 1'b0;
            rx_endless_out <= 1'b0;
        end else if (ce_in) begin
            rx_buf_wr_out <= rx_sym_valid_in && frame_lock_ff && rx_mode != `MSR_RX_SER;
            if (rx_sym_valid_in && rx_mode == `MSR_RX_SER) begin
                rx_pin_data_out <= rx_sym_in;
            end
            rx_wrap_out <= rx_mode == `MSR_RX_LOOP;
            rx_endless_out <= rx_mode == `MSR_RX_SER || rx_mode == `MSR_RX_LOOP;
        end
    end

    msr_txseq_t seq_ff;
    msr_txseq_t nxt_seq;
    logic [1:0] idx_ff;
    logic [1:0] nxt_idx;
    logic [15:0] lfsr_ff;
    logic [15:0] sync_shift;
    msr_nib_t sync_nib;
    msr_nib_t nxt_nib;
    logic nxt_nib_valid;
    logic nxt_buf_rd;

    assign sync_shift = sync_ff >> {idx_ff, 2'b00};

    assign sync_nib = (sync_shift[3:0] == `MSR_NIB_ALL1) ? `MSR_NIB_ZERO : sync_shift[3:0];

    always_comb begin
        nxt_seq = seq_ff;
        nxt_idx = idx_ff;
        nxt_nib = tx_nib_out;
        nxt_nib_valid = 1'b0;
        nxt_buf_rd = 1'b0;
        unique case (seq_ff)
            SQ_IDLE: begin
                if (tx_start_in) begin
                    nxt_seq = SQ_SYNC;
                    nxt_idx = 2'h0;
                end
            end
            SQ_SYNC: begin
                if (sym_tick_in) begin
                    nxt_nib = sync_nib;
                    nxt_nib_valid = 1'b1;
                    nxt_idx = idx_ff + 2'h1;
                    if (idx_ff == `MSR_SYNC_LAST) begin
                        nxt_seq = SQ_DATA;
                    end
                end
            end
            SQ_DATA: begin
                if (tx_stop_in && tx_mode == `MSR_TX_BUF) begin
                    nxt_seq = SQ_IDLE;
                end else if (sym_tick_in) begin
                    nxt_nib_valid = 1'b1;
                    unique case (tx_mode)
                        `MSR_TX_BUF, `MSR_TX_LOOP: begin
                            nxt_nib = tx_buf_nib_in;
                            nxt_buf_rd = 1'b1;
                        end
                        `MSR_TX_SER: nxt_nib = tx_ser_nib_in;
                        `MSR_TX_RAND: nxt_nib = lfsr_ff[3:0];
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            seq_ff <= SQ_IDLE;
            idx_ff <= 2'h0;
            tx_nib_out <= `MSR_NIB_ZERO;
            tx_nib_valid_out <= 1'b0;
            tx_buf_rd_out <= 1'b0;
            tx_busy_out <= 1'b0;
            tx_wrap_out <= 1'b0;
            tx_endless_out <= 1'b0;
        end else if (ce_in) begin
            seq_ff <= nxt_seq;
            idx_ff <= nxt_idx;
            tx_nib_out <= nxt_nib;
            tx_nib_valid_out <= nxt_nib_valid;
            tx_buf_rd_out <= nxt_buf_rd;
            tx_busy_out <= nxt_seq != SQ_IDLE;
            tx_wrap_out <= tx_mode == `MSR_TX_LOOP;
            tx_endless_out <= tx_mode != `MSR_TX_BUF;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lfsr_ff <= `MSR_LFSR_RST;
        end else if (ce_in && seq_ff == SQ_DATA && sym_tick_in && tx_mode == `MSR_TX_RAND) begin
            lfsr_ff <= {lfsr_ff[14:0], 1'b0} ^ (lfsr_ff[15] ? `MSR_LFSR_POLY : 16'h0000);
        end
    end

    property p_corr_gate;
        ce_in |=> delim_search_en_out == ($past(corr_level_in) >= $past(correlator_threshold));
    endproperty
    a_corr_gate: assert property (p_corr_gate) else $error("search gate wrong");

    property p_delim_gate;
        delim_found_out |-> $past(delim_search_en_out) && $past(rx_sym_valid_in);
    endproperty
    a_delim_gate: assert property (p_delim_gate) else $error("delimiter without gate");

    property p_hold;
        ce_in && rx_en_in && preamble_match_in && !ctrl_ff[`MSR_AVG_BIT] |=> offset_hold_out;
    endproperty
    a_hold: assert property (p_hold) else $error("offset filter not frozen");

    property p_phase;
        ce_in |=> phase_reverse_out == $past(ctrl_ff[`MSR_PHASE_BIT]);
    endproperty
    a_phase: assert property (p_phase) else $error("phase select wrong");

    property p_buf_rd;
        tx_buf_rd_out |-> !$past(tx_mode[0]) && $past(seq_ff == SQ_DATA);
    endproperty
    a_buf_rd: assert property (p_buf_rd) else $error("buffer read in wrong mode");

    property p_endless;
        ce_in && seq_ff == SQ_DATA && tx_stop_in && tx_mode != `MSR_TX_BUF |=> tx_busy_out;
    endproperty
    a_endless: assert property (p_endless) else $error("endless transmit stopped");

    property p_rx_pins;
        ce_in && rx_sym_valid_in && rx_mode == `MSR_RX_SER
            |=> rx_pin_data_out == $past(rx_sym_in) && !rx_buf_wr_out;
    endproperty
    a_rx_pins: assert property (p_rx_pins) else $error("pin data wrong");

    property p_level_clear;
        ce_in && clear_channel_rule_select_in == `MSR_CCA_LEVEL && s_val >= s_thr
            |=> !clear_channel_flag_out;
    endproperty
    a_level_clear: assert property (p_level_clear) else $error("flag high above threshold");

    property p_invalid;
        !avg_bus.valid |-> avg_bus.avg == `MSR_STRENGTH_INVALID;
    endproperty
    a_invalid: assert property (p_invalid) else $error("estimate shown while not ready");

    property p_sync_first;
        ce_in && seq_ff == SQ_SYNC && sym_tick_in && idx_ff == 2'h0
            |=> tx_nib_valid_out && tx_nib_out == (($past(sync_ff[3:0]) == `MSR_NIB_ALL1)
            ? `MSR_NIB_ZERO : $past(sync_ff[3:0]));
    endproperty
    a_sync_first: assert property (p_sync_first) else $error("first sync nibble wrong");

    property p_thr_write;
        wr_strength |=> thr_ff == $past(reg_wdata_in[`MSR_THR_HI:`MSR_THR_LO]) &&
            (avg_bus.avg == $past(avg_bus.avg) || $past(avg_bus.tick || avg_bus.clear));
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("strength write not ignored");

    c_delim: cover property (delim_found_out);
    c_flag: cover property ($rose(clear_channel_flag_out));
    c_sync_done: cover property (seq_ff == SQ_SYNC ##1 seq_ff == SQ_DATA);
    c_ready: cover property ($rose(signal_strength_ready_out));
endmodule // msr_modem_regs
`default_nettype wire

// file: test/msr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module msr_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output logic [5:0] addr_out,
    output logic [15:0] wdata_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 6'h00;
        wdata_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = (a == 6'h12) ? {5'h00, d[10:0]} : d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~wdata_out;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        @(negedge clk_in);
        d = rdata_in;
    endtask
endmodule // msr_host_model
`default_nettype wire

// file: test/test_msr_modem_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
    $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module test_msr_modem_regs;
    import msr_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr, rd, pm = 1'b0, rxen = 1'b0, tick = 1'b0;
    logic sv = 1'b0, fend = 1'b0, start = 1'b0, stop = 1'b0, srch, found, hold;
    logic phr, rdy, ccf, bwr, rwrap, rend, tnv, tbr, twrap, tend, busy;
    logic [5:0] addr;
    logic [15:0] wd, rdat, d;
    logic [4:0] corr = 5'h00;
    msr_db_t smp = 8'h10;
    msr_nib_t sym = 4'h0, pin, tnib;
    int mismatches = 0, samples_checked = 0;
    always #25 clk = ~clk;
    msr_host_model msr_host_model_inst (.clk_in(clk), .rdata_in(rdat), .addr_out(addr),
        .wdata_out(wd), .wr_out(wr), .rd_out(rd));
    msr_modem_regs msr_modem_regs_inst (.sys_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .corr_level_in(corr), .preamble_match_in(pm), .rx_en_in(rxen),
        .strength_sample_in(smp), .sym_tick_in(tick), .clear_channel_rule_select_in(2'h1),
        .clear_channel_hysteresis_in(3'h0), .rx_frame_active_in(1'b0),
        .rx_sym_valid_in(sv), .rx_sym_in(sym), .rx_frame_end_in(fend),
        .tx_start_in(start), .tx_stop_in(stop), .tx_buf_nib_in(4'h5),
        .tx_ser_nib_in(4'h9), .reg_rdata_out(rdat), .delim_search_en_out(srch),
        .delim_found_out(found), .offset_hold_out(hold), .phase_reverse_out(phr),
        .signal_strength_ready_out(rdy), .clear_channel_flag_out(ccf),
        .rx_buf_wr_out(bwr), .rx_pin_data_out(pin), .rx_wrap_out(rwrap),
        .rx_endless_out(rend), .tx_nib_out(tnib), .tx_nib_valid_out(tnv),
        .tx_buf_rd_out(tbr), .tx_wrap_out(twrap), .tx_endless_out(tend),
        .tx_busy_out(busy));
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse_tick();
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        cyc(1);
    endtask
    task automatic t_reset_regs();
        msr_host_model_inst.rd(6'h12, d);
        `CHK(d, 16'h0500)
        msr_host_model_inst.rd(6'h13, d);
        `CHK(d, 16'he080)
        msr_host_model_inst.rd(6'h14, d);
        `CHK(d, 16'ha70f)
        msr_host_model_inst.wr(6'h13, 16'h1234);
        ce = 1'b0;
        msr_host_model_inst.wr(6'h13, 16'h5500);
        ce = 1'b1;
        msr_host_model_inst.rd(6'h13, d);
        `CHK(d, 16'h1280)
        msr_host_model_inst.rd(6'h2a, d);
        `CHK(d, 16'h0000)
        msr_host_model_inst.wr(6'h13, 16'he000);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 3; m++) begin
            msr_host_model_inst.wr(6'h12, 16'hf510 | 16'(m * 5));
            sym = 4'hc;
            sv = 1'b1;
            cyc(1);
            sv = 1'b0;
            cyc(1);
            `CHK(rend, (m != 0))
            `CHK(rwrap, (m == 2))
            `CHK(tend, (m != 0))
            `CHK(twrap, (m == 2))
            `CHK(pin, ((m == 0) ? 4'h0 : 4'hc))
            `CHK(phr, 1'b1)
        end
        msr_host_model_inst.wr(6'h12, 16'h0500);
        rxen = 1'b1;
        pm = 1'b1;
        cyc(1);
        pm = 1'b0;
        cyc(2);
        `CHK(hold, 1'b1)
        msr_host_model_inst.wr(6'h12, 16'h0520);
        cyc(2);
        `CHK(hold, 1'b0)
        msr_host_model_inst.wr(6'h12, 16'h0500);
        rxen = 1'b0;
    endtask
    task automatic t_rx_sync(input logic [4:0] lvl, input logic exp);
        logic seen;
        logic [3:0] s [5];
        s = '{4'h0, 4'h0, 4'h0, 4'h7, 4'ha};
        seen = 1'b0;
        corr = lvl;
        rxen = 1'b1;
        cyc(2);
        `CHK(srch, exp)
        foreach (s[i]) begin
            sym = s[i];
            sv = 1'b1;
            cyc(1);
            sv = 1'b0;
            seen = seen | found;
            cyc(1);
            seen = seen | found;
        end
        cyc(1);
        seen = seen | found;
        `CHK(seen, exp)
        sym = 4'h3;
        sv = 1'b1;
        cyc(1);
        sv = 1'b0;
        `CHK(bwr, exp)
        rxen = 1'b0;
        cyc(2);
    endtask
    task automatic t_strength();
        rxen = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i == 7) begin
                `CHK(rdy, 1'b0)
                `CHK(ccf, 1'b1)
            end
            pulse_tick();
            cyc(2);
        end
        `CHK(rdy, 1'b1)
        `CHK(ccf, 1'b0)
        msr_host_model_inst.rd(6'h13, d);
        `CHK(d, 16'he010)
        rxen = 1'b0;
    endtask
    task automatic t_tx(input logic [1:0] mode, input logic [3:0] dat);
        logic [3:0] e [4];
        e = '{4'h0, 4'h0, 4'h7, 4'ha};
        msr_host_model_inst.wr(6'h12, {12'h050, mode, 2'h0});
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(1);
        `CHK(busy, 1'b1)
        foreach (e[i]) begin
            tick = 1'b1;
            cyc(1);
            tick = 1'b0;
            `CHK(tnv, 1'b1)
            `CHK(tnib, e[i])
            cyc(2);
        end
        tick = 1'b1;
        cyc(1);
        tick = 1'b0;
        `CHK(tnib, dat)
        `CHK(tbr, !mode[0])
        stop = 1'b1;
        cyc(1);
        stop = 1'b0;
        `CHK(busy, (mode != 2'h0))
        msr_host_model_inst.wr(6'h12, 16'h0500);
        stop = 1'b1;
        cyc(1);
        stop = 1'b0;
        cyc(1);
        `CHK(busy, 1'b0)
    endtask
    initial begin
        cyc(12);
        rstn = 1'b1;
        cyc(1);
        t_reset_regs();
        t_modes();
        t_rx_sync(5'd20, 1'b1);
        t_rx_sync(5'd19, 1'b0);
        t_strength();
        t_tx(2'h0, 4'h5);
        t_tx(2'h3, 4'hf);
        close_out();
    end
    initial begin
        #(50 * 20000);
        mismatches++;
        close_out();
    end
endmodule // test_msr_modem_regs
`default_nettype wire
